//--- verilog/cpc_top.v
// synthesizer channel, band and calibration control registers
`include "cpc_regs.vh"
`default_nettype none

module cpc_top (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_we,
  input wire reg_re,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  input wire synth_lock_pin,
  input wire cf_cal_done,
  input wire [4:0] cf_cal_state_in,
  input wire filter_tune_done,
  input wire transceiver_off_state_entry,
  output reg cf_cal_run_r,
  output reg delay_cal_run_r,
  output reg filter_tune_run_r,
  output reg [13:0] carrier_freq_r,
  output reg carrier_valid_r,
  output reg [4:0] cf_cal_state_r
);

  // --------------------------------------------------------------------------
  // timing counts
  // --------------------------------------------------------------------------
  // limits count system clocks from the edge that takes the start
  localparam integer CF_CYC = `CPC_CF_MAX_US * `CPC_CLK_MHZ;
  localparam integer DC_CYC = `CPC_DC_RUN_US * `CPC_CLK_MHZ;
  localparam integer FT_CYC = `CPC_FT_MAX_US * `CPC_CLK_MHZ;
  localparam integer CAL_CF = 0;
  localparam integer CAL_DC = 1;
  localparam integer CAL_FT = 2;

  // --------------------------------------------------------------------------
  // reset release and pin synchroniser
  // --------------------------------------------------------------------------
  reg rst_meta_r;
  reg rst_sync_r;
  reg lock_meta_r;
  reg lock_sync_r;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // lock comes from the analog loop, so it is retimed before use
  always @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end else begin
      lock_meta_r <= synth_lock_pin;
      lock_sync_r <= lock_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  reg [4:0] channel_r;
  reg [7:0] carrier_number_r;
  reg [2:0] band_select_r;
  reg [1:0] cf_rsv_r;
  reg [6:0] dc_rsv_r;
  reg [6:0] ft_rsv_r;
  reg synth_lock_flag_r;

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  wire wr_channel;
  wire wr_carrier;
  wire wr_band;
  wire wr_ftune;
  wire wr_cfcal;
  wire wr_dcal;
  wire start_bit;
  wire [2:0] cal_start;
  wire [2:0] cal_done;
  wire [2:0] cal_busy;

  assign wr_channel = reg_we && (reg_addr == `CPC_ADDR_CHANNEL);
  assign wr_carrier = reg_we && (reg_addr == `CPC_ADDR_CARRIER);
  assign wr_band = reg_we && (reg_addr == `CPC_ADDR_BAND);
  assign wr_ftune = reg_we && (reg_addr == `CPC_ADDR_FTUNE);
  assign wr_cfcal = reg_we && (reg_addr == `CPC_ADDR_CFCAL);
  assign wr_dcal = reg_we && (reg_addr == `CPC_ADDR_DCAL);
  assign start_bit = reg_wdata[`CPC_START_BIT];

  always @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      channel_r <= `CPC_RST_CHANNEL;
      carrier_number_r <= `CPC_RST_CARRIER;
      band_select_r <= `CPC_RST_BAND;
      synth_lock_flag_r <= 1'b0;
    end else begin
      synth_lock_flag_r <= lock_sync_r;
      if (wr_channel) begin
        channel_r <= reg_wdata[`CPC_CH_HI:0];
      end
      if (wr_carrier) begin
        carrier_number_r <= reg_wdata;
      end
      if (wr_band) begin
        band_select_r <= reg_wdata[`CPC_BAND_HI:0];
      end
    end
  end

  // reserved fields are stored as written; software keeps them intact,
  // so a careless write changes what later reads return
  always @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cf_rsv_r <= `CPC_RST_CF_RSV;
      dc_rsv_r <= `CPC_RST_DC_RSV;
      ft_rsv_r <= `CPC_RST_FT_RSV;
    end else begin
      if (wr_cfcal) begin
        cf_rsv_r <= reg_wdata[`CPC_RSV_HI:`CPC_CF_RSV_LO];
      end
      if (wr_dcal) begin
        dc_rsv_r <= reg_wdata[`CPC_RSV_HI:`CPC_DC_RSV_LO];
      end
      if (wr_ftune) begin
        ft_rsv_r <= reg_wdata[`CPC_RSV_HI:`CPC_FT_RSV_LO];
      end
    end
  end

  // --------------------------------------------------------------------------
  // centre-frequency calibration state
  // --------------------------------------------------------------------------
  // while the loop runs the synthesizer owns the value, so its update
  // wins over a software write in the same cycle
  always @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cf_cal_state_r <= `CPC_RST_CFST;
    end else if (cal_busy[CAL_CF]) begin
      cf_cal_state_r <= cf_cal_state_in;
    end else if (wr_cfcal) begin
      cf_cal_state_r <= reg_wdata[`CPC_CFST_HI:0];
    end
  end

  // --------------------------------------------------------------------------
  // calibration sequencers
  // --------------------------------------------------------------------------
  assign cal_start[CAL_CF] = wr_cfcal && start_bit;
  assign cal_start[CAL_DC] = wr_dcal && start_bit;
  assign cal_start[CAL_FT] = (wr_ftune && start_bit) || transceiver_off_state_entry;
  assign cal_done[CAL_CF] = cf_cal_done;
  assign cal_done[CAL_DC] = 1'b0;
  assign cal_done[CAL_FT] = filter_tune_done;

  // the delay loop has no done input and always runs its full time
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cal
      cpc_cal_timer #(
        .RUN_CYC((gi == CAL_DC) ? DC_CYC : ((gi == CAL_CF) ? CF_CYC : FT_CYC)),
        .USE_DONE((gi == CAL_DC) ? 0 : 1)
      ) u_timer (
        .mclk(mclk),
        .rst_n(rst_sync_r),
        .start(cal_start[gi]),
        .done(cal_done[gi]),
        .busy_r(cal_busy[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // run outputs
  // --------------------------------------------------------------------------
  always @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cf_cal_run_r <= 1'b0;
      delay_cal_run_r <= 1'b0;
      filter_tune_run_r <= 1'b0;
    end else begin
      cf_cal_run_r <= cal_busy[CAL_CF];
      delay_cal_run_r <= cal_busy[CAL_DC];
      filter_tune_run_r <= cal_busy[CAL_FT];
    end
  end

  // --------------------------------------------------------------------------
  // carrier frequency, units of 100 kHz
  // --------------------------------------------------------------------------
  reg [13:0] freq_nxt;
  reg valid_nxt;
  wire [13:0] num_w;
  wire [13:0] ch_w;
  wire [13:0] ch_step;
  wire [13:0] mhz_step;

  assign num_w = {6'h00, carrier_number_r};
  assign ch_w = {9'h000, channel_r};
  assign ch_step = (ch_w - 14'h0001) * `CPC_F_CH_STEP;
  assign mhz_step = num_w * `CPC_F_MHZ_STEP;

  always @* begin
    freq_nxt = 14'h0000;
    valid_nxt = 1'b0;
    case (band_select_r)
      3'h0: begin
        if (channel_r == 5'h00) begin
          freq_nxt = `CPC_F_CH0;
          valid_nxt = 1'b1;
        end else if (channel_r <= `CPC_CH_MAX) begin
          freq_nxt = `CPC_F_CH1 + ch_step;
          valid_nxt = 1'b1;
        end
      end
      3'h1: begin
        freq_nxt = `CPC_F_BAND1 + num_w;
        valid_nxt = 1'b1;
      end
      3'h2: begin
        freq_nxt = `CPC_F_BAND2 + num_w;
        valid_nxt = 1'b1;
      end
      3'h3: begin
        freq_nxt = `CPC_F_BAND3 + num_w;
        valid_nxt = 1'b1;
      end
      3'h4: begin
        freq_nxt = `CPC_F_BAND4 + mhz_step;
        valid_nxt = 1'b1;
      end
      3'h5: begin
        freq_nxt = `CPC_F_BAND5 + mhz_step;
        valid_nxt = 1'b1;
      end
      default: begin
        freq_nxt = 14'h0000;
        valid_nxt = 1'b0;
      end
    endcase
  end

  // numbers outside a band's printed range still compute; only the
  // reserved channel codes and bands drop the valid flag
  always @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      carrier_freq_r <= 14'h0000;
      carrier_valid_r <= 1'b0;
    end else begin
      carrier_freq_r <= freq_nxt;
      carrier_valid_r <= valid_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // read port
  // --------------------------------------------------------------------------
  reg [7:0] rdata_nxt;
  wire [7:0] rd_channel;
  wire [7:0] rd_monitor;
  wire [7:0] rd_carrier;
  wire [7:0] rd_band;
  wire [7:0] rd_ftune;
  wire [7:0] rd_cfcal;
  wire [7:0] rd_dcal;

  // start bits read the live busy level, so software can poll them
  assign rd_channel = {3'h0, channel_r};
  assign rd_monitor = {synth_lock_flag_r, 7'h00};
  assign rd_carrier = carrier_number_r;
  assign rd_band = {5'h00, band_select_r};
  assign rd_ftune = {cal_busy[CAL_FT], ft_rsv_r};
  assign rd_cfcal = {cal_busy[CAL_CF], cf_rsv_r, cf_cal_state_r};
  assign rd_dcal = {cal_busy[CAL_DC], dc_rsv_r};

  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `CPC_ADDR_CHANNEL: rdata_nxt = rd_channel;
      `CPC_ADDR_MONITOR: rdata_nxt = rd_monitor;
      `CPC_ADDR_CARRIER: rdata_nxt = rd_carrier;
      `CPC_ADDR_BAND: rdata_nxt = rd_band;
      `CPC_ADDR_FTUNE: rdata_nxt = rd_ftune;
      `CPC_ADDR_CFCAL: rdata_nxt = rd_cfcal;
      `CPC_ADDR_DCAL: rdata_nxt = rd_dcal;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data holds until the next read strobe
  always @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_re) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

endmodule // cpc_top

`default_nettype wire

//--- verilog/cpc_regs.vh
// register map, field layout and timing constants of the synthesizer control
// ----------------------------------------------------------------------------
// How it works
// - code 0 gives 868.3 MHz, codes k=1-10 give 906+2(k-1) MHz, rest reserved
// - eight-bit carrier number, reset zero, used when channel mode is off
// - three-bit band field in bits 2:0, upper bits read-only zero
// - cf_cal_start write of one runs calibration, cleared within 25 us
// - cf_cal_state bits 4:0 follow the synthesizer while calibration runs, read/write otherwise
// - delay_cal_start runs 10 us then clears at once
// - bit 7 of the monitor register is the read-only lock flag, reset zero
// - entry to transceiver-off from sleep, reset, power-on starts tuning
// - filter_tune_start set-only bit 7; reserved 6:4 reset 101, r/w
// - filter_tune_start clears by hardware within 25 us of start
// - band zero uses channel field, bands 1-5 use carrier number
// - bands 1-3 step 0.1 MHz, bands 4-5 step 1 MHz, 6-7 reserved
// ----------------------------------------------------------------------------
`ifndef CPC_REGS_VH
`define CPC_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define CPC_ADDR_CHANNEL 8'h08
`define CPC_ADDR_MONITOR 8'h11
`define CPC_ADDR_CARRIER 8'h13
`define CPC_ADDR_BAND 8'h14
`define CPC_ADDR_FTUNE 8'h18
`define CPC_ADDR_CFCAL 8'h1A
`define CPC_ADDR_DCAL 8'h1B

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CPC_START_BIT 7
`define CPC_LOCK_BIT 7
`define CPC_CH_HI 4
`define CPC_BAND_HI 2
`define CPC_CFST_HI 4
`define CPC_RSV_HI 6
`define CPC_CF_RSV_LO 5
`define CPC_DC_RSV_LO 0
`define CPC_FT_RSV_LO 0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CPC_RST_CHANNEL 5'h00
`define CPC_RST_CARRIER 8'h00
`define CPC_RST_BAND 3'h0
`define CPC_RST_CFST 5'h00
`define CPC_RST_CF_RSV 2'h2
`define CPC_RST_DC_RSV 7'h40
`define CPC_RST_FT_RSV 7'h50

// ----------------------------------------------------------------------------
// frequency plan, units of 100 kHz
// ----------------------------------------------------------------------------
`define CPC_CH_MAX 5'h0A
`define CPC_F_CH0 14'h21EB
`define CPC_F_CH1 14'h2364
`define CPC_F_CH_STEP 14'h0014
`define CPC_F_BAND1 14'h1E0A
`define CPC_F_BAND2 14'h217A
`define CPC_F_BAND3 14'h2346
`define CPC_F_BAND4 14'h1E0A
`define CPC_F_BAND5 14'h208A
`define CPC_F_MHZ_STEP 14'h000A

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CPC_CLK_MHZ 10
`define CPC_CF_MAX_US 25
`define CPC_DC_RUN_US 10
`define CPC_FT_MAX_US 25

`endif

//--- verilog/cpc_cal_timer.v
// one calibration run: busy from start until done or the cycle limit
`default_nettype none

module cpc_cal_timer #(
  parameter integer RUN_CYC = 250,
  parameter integer USE_DONE = 1
) (
  input wire mclk,
  input wire rst_n,
  input wire start,
  input wire done,
  output reg busy_r
);

  reg [15:0] cnt_r;
  wire last;

  assign last = (cnt_r == RUN_CYC[15:0] - 16'h0001) ||
                ((USE_DONE != 0) && done);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r <= 16'h0000;
    end else if (!busy_r) begin
      // a start while running is ignored below, so nothing restarts
      if (start) begin
        busy_r <= 1'b1;
        cnt_r <= 16'h0000;
      end
    end else if (last) begin
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

endmodule // cpc_cal_timer

`default_nettype wire

//--- dv/cpc_chk.sv
// port-level checker of the synthesizer control register block
`default_nettype none
module cpc_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_r,
  input wire logic cf_cal_done,
  input wire logic filter_tune_done,
  input wire logic transceiver_off_state_entry,
  input wire logic cf_cal_run_r,
  input wire logic delay_cal_run_r,
  input wire logic filter_tune_run_r
);
  // ----
  // run-length counters
  // ----
  logic [1:0] age_r;
  logic [8:0] dc_r;
  logic [8:0] cf_r;
  logic [8:0] ft_r;
  // age gates triggers: the synced reset rises two edges after rst_n
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      age_r <= 2'h0;
      dc_r <= 9'h000;
      cf_r <= 9'h000;
      ft_r <= 9'h000;
    end else begin
      if (age_r != 2'h3)
        age_r <= age_r + 2'h1;
      dc_r <= delay_cal_run_r ? dc_r + 9'h001 : 9'h000;
      cf_r <= cf_cal_run_r ? cf_r + 9'h001 : 9'h000;
      ft_r <= filter_tune_run_r ? ft_r + 9'h001 : 9'h000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_DC_LEN: assert property ($fell(delay_cal_run_r) |-> dc_r == 9'h064)
    else $error("delay run length wrong");
  AST_DC_GO: assert property (age_r == 2'h3 && reg_we && reg_addr == 8'h1B
    && reg_wdata[7] && !delay_cal_run_r |-> ##2 delay_cal_run_r)
    else $error("delay run did not start");
  AST_CF_CEIL: assert property (cf_r <= 9'h0FA)
    else $error("cf run too long");
  AST_FT_CEIL: assert property (ft_r <= 9'h0FA)
    else $error("filter run too long");
  AST_CF_END: assert property (cf_cal_run_r && cf_cal_done && !reg_we
    |-> ##2 !cf_cal_run_r)
    else $error("cf run did not end");
  AST_FT_END: assert property (filter_tune_run_r && filter_tune_done
    && !reg_we && !transceiver_off_state_entry |-> ##2 !filter_tune_run_r)
    else $error("filter run did not end");
  AST_FT_AUTO: assert property (age_r == 2'h3 && transceiver_off_state_entry
    && !filter_tune_run_r && !filter_tune_done |-> ##2 filter_tune_run_r)
    else $error("filter run not started");
  AST_MON_RD: assert property (reg_re && reg_addr == 8'h11
    |=> reg_rdata_r[6:0] == 7'h00)
    else $error("monitor low bits not zero");
  AST_BAND_RD: assert property (reg_re && reg_addr == 8'h14
    |=> reg_rdata_r[7:3] == 5'h00)
    else $error("band upper bits not zero");
endmodule // cpc_chk
bind cpc_top cpc_chk i_chk (.mclk, .rst_n, .reg_addr, .reg_we, .reg_re,
  .reg_wdata, .reg_rdata_r, .cf_cal_done, .filter_tune_done, .transceiver_off_state_entry,
  .cf_cal_run_r, .delay_cal_run_r, .filter_tune_run_r);
`default_nettype wire

//--- dv/channel_pll_calibration_ctrl_tb.sv
// register-level testbench of the synthesizer control block
`default_nettype none
module channel_pll_calibration_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic synth_lock_pin = 1'b0;
  logic cf_cal_done = 1'b0;
  logic [4:0] cf_cal_state_in = 5'h00;
  logic filter_tune_done = 1'b0;
  logic transceiver_off_state_entry = 1'b0;
  logic [7:0] reg_rdata_r;
  logic cf_cal_run_r;
  logic delay_cal_run_r;
  logic filter_tune_run_r;
  logic [13:0] carrier_freq_r;
  logic carrier_valid_r;
  logic [4:0] cf_cal_state_r;
  int err_total = 0;
  int checks_done = 0;
  logic [7:0] ra [8] = '{8'h08, 8'h11, 8'h13, 8'h14, 8'h18, 8'h1A, 8'h1B,
    8'h20};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h40, 8'h40,
    8'h00};
  logic [15:0] bf [5] = '{16'h1E0A, 16'h217A, 16'h2346, 16'h1E0A, 16'h208A};
  cpc_top i_dut (.mclk, .rst_n, .reg_addr, .reg_we, .reg_re, .reg_wdata,
    .reg_rdata_r, .synth_lock_pin, .cf_cal_done, .cf_cal_state_in,
    .filter_tune_done, .transceiver_off_state_entry, .cf_cal_run_r, .delay_cal_run_r,
    .filter_tune_run_r, .carrier_freq_r, .carrier_valid_r, .cf_cal_state_r);
  always #50 mclk = ~mclk;
  // ----
  // access tasks, entered at a falling edge except the first do_reset at time 0
  // ----
  task automatic print_verdict;
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    cyc(1);
    reg_we = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_re = 1'b1;
    cyc(1);
    reg_re = 1'b0;
    cyc(1);
    chk({8'h00, reg_rdata_r}, {8'h00, e});
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    cyc(3);
    for (int i = 0; i < 8; i++)
      rd(ra[i], rv[i]);
  endtask
  // counts cycles a run output stays high; bounded
  task automatic run_len(input int s, input logic [15:0] e);
    int n;
    n = 0;
    for (int t = 0; t < 400; t++) begin
      if (s == 0 ? delay_cal_run_r : s == 1 ? cf_cal_run_r : filter_tune_run_r)
        n++;
      else if (n > 0) begin
        chk(n[15:0], e);
        return;
      end
      cyc(1);
    end
    err_total++;
    print_verdict;
  endtask
  initial begin
    do_reset;
    chk({1'b0, carrier_valid_r, carrier_freq_r}, 16'h61EB);
    for (int k = 0; k < 12; k++) begin
      wr(8'h08, k[7:0]);
      cyc(2);
      chk({15'h0, carrier_valid_r}, {15'h0, k < 11});
      if (k < 11)
        chk({2'h0, carrier_freq_r}, k == 0 ? 16'h21EB
          : 16'h2364 + 16'(16'h0014 * (k - 1)));
    end
    wr(8'h13, 8'h05);
    rd(8'h13, 8'h05);
    for (int b = 1; b < 8; b++) begin
      wr(8'h14, b[7:0]);
      cyc(2);
      chk({15'h0, carrier_valid_r}, {15'h0, b < 6});
      if (b < 6)
        chk({2'h0, carrier_freq_r},
          bf[b - 1] + (b < 4 ? 16'h0005 : 16'h0032));
    end
    wr(8'h14, 8'hFF);
    rd(8'h14, 8'h07);
    synth_lock_pin = 1'b1;
    cyc(4);
    rd(8'h11, 8'h80);
    synth_lock_pin = 1'b0;
    cyc(4);
    rd(8'h11, 8'h00);
    wr(8'h1B, 8'hC0);
    run_len(0, 16'd100);
    wr(8'h1B, 8'hC0);
    rd(8'h1B, 8'hC0);
    wr(8'h1B, 8'hC0);
    cyc(98);
    rd(8'h1B, 8'h40);
    cf_cal_state_in = 5'h0B;
    wr(8'h1A, 8'hC0);
    cyc(3);
    rd(8'h1A, 8'hCB);
    cf_cal_done = 1'b1;
    cyc(1);
    cf_cal_done = 1'b0;
    cyc(3);
    rd(8'h1A, 8'h4B);
    wr(8'h1A, 8'hCB);
    run_len(1, 16'd250);
    wr(8'h1A, 8'h53);
    rd(8'h1A, 8'h53);
    chk({11'h0, cf_cal_state_r}, 16'h0013);
    transceiver_off_state_entry = 1'b1;
    cyc(1);
    transceiver_off_state_entry = 1'b0;
    cyc(2);
    rd(8'h18, 8'hD0);
    filter_tune_done = 1'b1;
    cyc(1);
    filter_tune_done = 1'b0;
    cyc(3);
    rd(8'h18, 8'h50);
    wr(8'h18, 8'hA0);
    run_len(2, 16'd250);
    rd(8'h18, 8'h20);
    wr(8'h1B, 8'hC0);
    cyc(5);
    do_reset;
    print_verdict;
  end
endmodule // channel_pll_calibration_ctrl_tb
`default_nettype wire
